// File: hdl/pasc_pkg.sv
package pasc_pkg;

	localparam logic [7:0] ADDR_ALERT_ENABLE_EXT   = 8'h32;
	localparam logic [7:0] ADDR_PIN_FUNCTION_CFG   = 8'h33;
	localparam logic [7:0] ADDR_STATUS_EXT         = 8'h40;
	localparam logic [7:0] ADDR_PIN_THREE_OUT_CTRL = 8'h42;

	localparam logic [7:0] RST_ALERT_ENABLE_EXT = 8'h00;
	localparam logic [7:0] RST_PIN_FUNCTION_CFG = 8'h00;
	localparam logic [7:0] RST_PIN_THREE_CTRL   = 8'h00;

	localparam int AE_CONV_DONE  = 7;
	localparam int AE_PIN_ONE    = 6;
	localparam int AE_PIN_TWO    = 5;
	localparam int AE_STUCK_WAKE = 3;
	localparam int AE_ENERGY_OVF = 2;
	localparam int AE_CHARGE_OVF = 1;
	localparam int AE_TIME_OVF   = 0;

	localparam int PF_ONE_HI    = 7;
	localparam int PF_ONE_LO    = 6;
	localparam int PF_TWO_HI    = 5;
	localparam int PF_TWO_LO    = 4;
	localparam int PF_THREE_HI  = 3;
	localparam int PF_THREE_LO  = 2;
	localparam int PF_TWO_LEVEL = 1;

	localparam int ST_PIN_ONE    = 6;
	localparam int ST_PIN_TWO    = 5;
	localparam int ST_PIN_THREE  = 4;
	localparam int ST_SNAP_BUSY  = 3;
	localparam int ST_ENERGY_OVF = 2;
	localparam int ST_CHARGE_OVF = 1;
	localparam int ST_TIME_OVF   = 0;

	localparam int PC_ALERT_GEN = 7;
	localparam int PC_PULL_DOWN = 6;

	localparam logic [1:0] FN_IN_HIGH = 2'h3;
	localparam logic [1:0] FN_IN_LOW  = 2'h2;
	localparam logic [1:0] FN_OUTPUT  = 2'h1;
	localparam logic [1:0] FN_SPECIAL = 2'h0;

	localparam logic [7:0] BYTE_ZERO = 8'h00;

endpackage

// File: hdl/pasc_pin_alert_status_control.sv
// Overview of operation
// - Conversion-done enable bit 7 raises an alert on each finished conversion.
// - Enable bit 6 alerts while pin one input sits at its active level.
// - Enable bit 5 alerts while pin two input sits at its active level.
// - Enable bit 3 alerts on stuck-bus wake-up from shutdown while stuck_bus_wake_enable is high.
// - Enable bit 2 alerts on energy accumulator overflow.
// - Enable bit 1 alerts on charge accumulator overflow.
// - Enable bit 0 alerts on time counter overflow.
// - Pin one field: 11 in high, 10 in low, 01 high-Z, 00 drive low.
// - Pin two field: inputs, 01 output follows bit 1, 00 accumulate gate.
// - Pin three field: inputs, 01 output by control register, 00 alert output.
// - Status bit 6 shows pin one active while configured as input.
// - Status bit 5 shows pin two active, or raw level in accumulate mode.
// - Status bit 4 shows pin three active while configured as input.
// - Status bit 3 shows snapshot conversion busy.
// - Status bits 2..0 show energy, charge, time overflow; live inputs, not reset.
// - Pin three alert output pulls low while alert-generated bit set; sticky.
// - Pin three output pull-down bit drives low when 1, high-Z when 0.
`timescale 1ns/1ps
module pasc_pin_alert_status_control
	import pasc_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic       regWrite,
	input  wire logic       regRead,
	input  wire logic [7:0] regAddr,
	input  wire logic [7:0] regWrData,
	output logic      [7:0] regRdData_ff,
	input  wire logic       convDone,
	input  wire logic       snapshotBusy,
	input  wire logic       stuckBusWake,
	input  wire logic       stuck_bus_wake_enable,
	input  wire logic       energyOvf,
	input  wire logic       chargeOvf,
	input  wire logic       timeOvf,
	input  wire logic       alertFirstBank,
	input  wire logic       pinOneIn,
	input  wire logic       pinTwoIn,
	input  wire logic       pinThreeIn,
	output logic            pinOneOe_ff,
	output logic            pinTwoOe_ff,
	output logic            pinThreeOe_ff,
	output logic            pinOneOut_ff,
	output logic            pinTwoOut_ff,
	output logic            pinThreeOut_ff,
	output logic            accumulateGate_ff
);

	logic [7:0] alertEnableExt_ff;
	logic [7:0] pinFunction_ff;
	logic [7:0] pinThreeCtrl_ff;
	logic [7:0] nxt_alertEnableExt;
	logic [7:0] nxt_pinFunction;
	logic [7:0] nxt_pinThreeCtrl;
	logic [7:0] nxt_regRdData;
	logic [7:0] statusExt;
	logic [1:0] fnOne;
	logic [1:0] fnTwo;
	logic [1:0] fnThree;
	logic       oneActive;
	logic       twoActive;
	logic       threeActive;
	logic       alertRequest;
	logic       nxt_pinOneOe;
	logic       nxt_pinTwoOe;
	logic       nxt_pinThreeOe;
	logic       nxt_accumulateGate;

	always_comb begin
		fnOne   = pinFunction_ff[PF_ONE_HI:PF_ONE_LO];
		fnTwo   = pinFunction_ff[PF_TWO_HI:PF_TWO_LO];
		fnThree = pinFunction_ff[PF_THREE_HI:PF_THREE_LO];
		// An input mode has the high field bit set; the low bit picks active high.
		oneActive   = fnOne[1] & ~(pinOneIn ^ fnOne[0]);
		twoActive   = fnTwo[1] & ~(pinTwoIn ^ fnTwo[0]);
		threeActive = fnThree[1] & ~(pinThreeIn ^ fnThree[0]);
	end

	always_comb begin
		statusExt                = BYTE_ZERO;
		statusExt[ST_PIN_ONE]    = oneActive;
		statusExt[ST_PIN_TWO]    = (fnTwo == FN_SPECIAL) ? pinTwoIn : twoActive;
		statusExt[ST_PIN_THREE]  = threeActive;
		statusExt[ST_SNAP_BUSY]  = snapshotBusy;
		statusExt[ST_ENERGY_OVF] = energyOvf;
		statusExt[ST_CHARGE_OVF] = chargeOvf;
		statusExt[ST_TIME_OVF]   = timeOvf;
	end

	// The first bank's alert arrives already gated by its own enables.
	always_comb begin
		alertRequest = alertFirstBank;
		alertRequest = alertRequest | (alertEnableExt_ff[AE_CONV_DONE] & convDone);
		alertRequest = alertRequest | (alertEnableExt_ff[AE_PIN_ONE] & oneActive);
		alertRequest = alertRequest | (alertEnableExt_ff[AE_PIN_TWO] & twoActive);
		alertRequest = alertRequest
			| (alertEnableExt_ff[AE_STUCK_WAKE] & stuckBusWake & stuck_bus_wake_enable);
		alertRequest = alertRequest | (alertEnableExt_ff[AE_ENERGY_OVF] & energyOvf);
		alertRequest = alertRequest | (alertEnableExt_ff[AE_CHARGE_OVF] & chargeOvf);
		alertRequest = alertRequest | (alertEnableExt_ff[AE_TIME_OVF] & timeOvf);
	end

	always_comb begin
		nxt_alertEnableExt = alertEnableExt_ff;
		nxt_pinFunction    = pinFunction_ff;
		nxt_pinThreeCtrl   = pinThreeCtrl_ff;
		if (regWrite) begin
			unique case (regAddr)
				ADDR_ALERT_ENABLE_EXT: begin
					nxt_alertEnableExt = regWrData;
				end
				ADDR_PIN_FUNCTION_CFG: begin
					nxt_pinFunction = regWrData;
				end
				ADDR_PIN_THREE_OUT_CTRL: begin
					// Only bits 7 and 6 exist; the rest read as zero.
					nxt_pinThreeCtrl = BYTE_ZERO;
					nxt_pinThreeCtrl[PC_ALERT_GEN] = regWrData[PC_ALERT_GEN];
					nxt_pinThreeCtrl[PC_PULL_DOWN] = regWrData[PC_PULL_DOWN];
				end
				default: begin
				end
			endcase
		end
		// A new alert beats a software clear in the same cycle.
		if (alertRequest) begin
			nxt_pinThreeCtrl[PC_ALERT_GEN] = 1'b1;
		end
	end

	always_comb begin
		nxt_regRdData = regRdData_ff;
		if (regRead) begin
			unique case (regAddr)
				ADDR_ALERT_ENABLE_EXT:   nxt_regRdData = alertEnableExt_ff;
				ADDR_PIN_FUNCTION_CFG:   nxt_regRdData = pinFunction_ff;
				ADDR_STATUS_EXT:         nxt_regRdData = statusExt;
				ADDR_PIN_THREE_OUT_CTRL: nxt_regRdData = pinThreeCtrl_ff;
				default:                 nxt_regRdData = BYTE_ZERO;
			endcase
		end
	end

	// All pins are open drain: the output level is always low, only the enable moves.
	always_comb begin
		nxt_pinOneOe       = (fnOne == FN_SPECIAL);
		nxt_pinTwoOe       = (fnTwo == FN_OUTPUT) & pinFunction_ff[PF_TWO_LEVEL];
		nxt_accumulateGate = (fnTwo == FN_SPECIAL) & pinTwoIn;
		unique case (fnThree)
			FN_OUTPUT:  nxt_pinThreeOe = pinThreeCtrl_ff[PC_PULL_DOWN];
			FN_SPECIAL: nxt_pinThreeOe = pinThreeCtrl_ff[PC_ALERT_GEN];
			default:    nxt_pinThreeOe = 1'b0;
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			alertEnableExt_ff <= RST_ALERT_ENABLE_EXT;
			pinFunction_ff    <= RST_PIN_FUNCTION_CFG;
			pinThreeCtrl_ff   <= RST_PIN_THREE_CTRL;
			regRdData_ff      <= BYTE_ZERO;
			pinOneOe_ff       <= 1'b0;
			pinTwoOe_ff       <= 1'b0;
			pinThreeOe_ff     <= 1'b0;
			pinOneOut_ff      <= 1'b0;
			pinTwoOut_ff      <= 1'b0;
			pinThreeOut_ff    <= 1'b0;
			accumulateGate_ff <= 1'b0;
		end else begin
			alertEnableExt_ff <= nxt_alertEnableExt;
			pinFunction_ff    <= nxt_pinFunction;
			pinThreeCtrl_ff   <= nxt_pinThreeCtrl;
			regRdData_ff      <= nxt_regRdData;
			pinOneOe_ff       <= nxt_pinOneOe;
			pinTwoOe_ff       <= nxt_pinTwoOe;
			pinThreeOe_ff     <= nxt_pinThreeOe;
			pinOneOut_ff      <= 1'b0;
			pinTwoOut_ff      <= 1'b0;
			pinThreeOut_ff    <= 1'b0;
			accumulateGate_ff <= nxt_accumulateGate;
		end
	end

endmodule

// File: verification/pasc_pin_asserts.sv
`timescale 1ns/1ps
module pasc_pin_asserts
	import pasc_pkg::*;
(
	input wire logic       clk, rstn, regWrite, regRead, snapshotBusy,
	input wire logic       energyOvf, chargeOvf, timeOvf, pinOneIn, pinTwoIn,
	input wire logic [7:0] regAddr, regWrData, regRdData_ff,
	input wire logic       pinOneOe_ff, pinTwoOe_ff, pinThreeOe_ff, accumulateGate_ff
);
	logic [7:0] cfg;
	logic       pd;
	wire        rs = regRead && regAddr == ADDR_STATUS_EXT;
	// Shadow copies of the written fields, so outputs can be tied to the byte that set them.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cfg <= 8'h00;
			pd <= 1'b0;
		end else if (regWrite) begin
			cfg <= (regAddr == ADDR_PIN_FUNCTION_CFG) ? regWrData : cfg;
			pd <= (regAddr == ADDR_PIN_THREE_OUT_CTRL) ? regWrData[PC_PULL_DOWN] : pd;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	property p_one; $past(rstn) |-> pinOneOe_ff == ($past(cfg[7:6]) == FN_SPECIAL); endproperty
	a_one: assert property (p_one) else $error("pin one drive");
	property p_two; $past(rstn) |-> pinTwoOe_ff == ($past(cfg[5:4]) == 2'h1 && $past(cfg[1])); endproperty
	a_two: assert property (p_two) else $error("pin two drive");
	property p_acc; $past(rstn) |-> accumulateGate_ff == ($past(cfg[5:4]) == 2'h0 && $past(pinTwoIn)); endproperty
	a_acc: assert property (p_acc) else $error("gate level");
	property p_pd; $past(rstn) && $past(cfg[3:2]) == 2'h1 |-> pinThreeOe_ff == $past(pd); endproperty
	a_pd: assert property (p_pd) else $error("pin three pull-down");
	property p_in3; $past(cfg[3]) |-> !pinThreeOe_ff; endproperty
	a_in3: assert property (p_in3) else $error("pin three input driven");
	property p_st; rs |=> regRdData_ff[3:0] == $past({snapshotBusy, energyOvf, chargeOvf, timeOvf}); endproperty
	a_st: assert property (p_st) else $error("status flags");
	property p_st1; rs && cfg[7:6] == FN_IN_HIGH |=> regRdData_ff[6] == $past(pinOneIn); endproperty
	a_st1: assert property (p_st1) else $error("pin one state");
	property p_st2; rs && cfg[5:4] == 2'h0 |=> regRdData_ff[5] == $past(pinTwoIn); endproperty
	a_st2: assert property (p_st2) else $error("pin two state");
	c_rd: cover property (rs);
	c_acc: cover property (accumulateGate_ff);
	c_al: cover property (pinThreeOe_ff && cfg[3:2] == FN_SPECIAL);
endmodule

// File: verification/pasc_pin_model.sv
`timescale 1ns/1ps
module pasc_pin_model (
	input  wire logic [2:0] oe,
	input  wire logic [2:0] extLow,
	output logic      [2:0] level
);
	// Open-drain pins with pull-ups: whichever side pulls low wins.
	assign level = ~(oe | extLow);
endmodule

// File: verification/test_pin_alert_status_control.sv
`timescale 1ns/1ps
module test_pin_alert_status_control;
	import pasc_pkg::*;
	logic       clk = 0, rstn = 0, regWrite = 0, regRead = 0, busy = 0, wakeEn = 0;
	logic [7:0] regAddr = 8'h00, regWrData = 8'h00, src = 8'h00, rdData;
	logic [2:0] ext = 3'h0, oe, level;
	logic       acc;
	int         err_total = 0, n_tests = 0;
	pasc_pin_alert_status_control DUT (.clk(clk), .rstn(rstn), .regWrite(regWrite),
		.regRead(regRead), .regAddr(regAddr), .regWrData(regWrData), .regRdData_ff(rdData),
		.convDone(src[7]), .snapshotBusy(busy), .stuckBusWake(src[3]),
		.stuck_bus_wake_enable(wakeEn), .energyOvf(src[2]), .chargeOvf(src[1]),
		.timeOvf(src[0]), .alertFirstBank(src[4]), .pinOneIn(level[0]), .pinTwoIn(level[1]),
		.pinThreeIn(level[2]), .pinOneOe_ff(oe[0]), .pinTwoOe_ff(oe[1]), .pinThreeOe_ff(oe[2]),
		.pinOneOut_ff(), .pinTwoOut_ff(), .pinThreeOut_ff(), .accumulateGate_ff(acc));
	pasc_pin_model u_pins (.oe(oe), .extLow(ext & ~{1'b0, src[5], src[6]}), .level(level));
	task tk; @(posedge clk); #1; endtask
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		{regAddr, regWrData, regWrite} = {a, d, 1'b1};
		tk; regWrite = 1'b0; tk;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		{regAddr, regRead} = {a, 1'b1};
		tk; regRead = 1'b0; tk;
		chk($sformatf("reg %h", a), e, rdData);
	endtask
	task automatic pulse(input int i);
		src[i] = 1'b1; tk; src[i] = 1'b0; tk; tk;
	endtask
	task conclude;
		$display("mismatches %0d of %0d checks", err_total, n_tests);
		if (err_total == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial forever #2.5 clk = ~clk;
	initial begin
		#100000;
		err_total++;
		conclude();
	end
	initial begin
		repeat (6) @(posedge clk);
		#1 rstn = 1'b1;
		tk; tk;
		rd(ADDR_ALERT_ENABLE_EXT, RST_ALERT_ENABLE_EXT);
		rd(ADDR_PIN_FUNCTION_CFG, RST_PIN_FUNCTION_CFG);
		rd(ADDR_STATUS_EXT, 8'h20);
		rd(ADDR_PIN_THREE_OUT_CTRL, RST_PIN_THREE_CTRL);
		rd(8'h50, BYTE_ZERO);
		chk("oe", 8'h01, {5'h0, oe});
		wr(ADDR_PIN_FUNCTION_CFG, 8'h40);
		chk("oe gate", 8'h01, {5'h0, oe[1:0], acc});
		{busy, src, ext} = {1'b1, 8'h05, 3'h2};
		wr(ADDR_PIN_FUNCTION_CFG, 8'hFC);
		rd(ADDR_STATUS_EXT, 8'h5D);
		wr(ADDR_PIN_FUNCTION_CFG, 8'hA8);
		rd(ADDR_STATUS_EXT, 8'h2D);
		{busy, src, ext, wakeEn} = {1'b0, 8'h00, 3'h3, 1'b1};
		wr(ADDR_PIN_FUNCTION_CFG, 8'hD6);
		wr(ADDR_PIN_THREE_OUT_CTRL, 8'h40);
		chk("oe", 8'h06, {5'h0, oe});
		rd(ADDR_PIN_THREE_OUT_CTRL, 8'h40);
		wr(ADDR_PIN_FUNCTION_CFG, 8'hF0);
		wr(ADDR_PIN_THREE_OUT_CTRL, 8'h00);
		for (int i = 0; i < 8; i++) begin
			wr(ADDR_ALERT_ENABLE_EXT, 8'h00);
			pulse(i);
			if (i != 4) rd(ADDR_PIN_THREE_OUT_CTRL, 8'h00);
			wr(ADDR_ALERT_ENABLE_EXT, 8'h01 << i);
			pulse(i);
			rd(ADDR_PIN_THREE_OUT_CTRL, 8'h80);
			chk("alert pin", 8'h04, {5'h0, oe});
			wr(ADDR_PIN_THREE_OUT_CTRL, 8'h00);
			chk("alert pin", 8'h00, {5'h0, oe});
		end
		wr(ADDR_PIN_THREE_OUT_CTRL, 8'h80);
		chk("alert pin", 8'h04, {5'h0, oe});
		conclude();
	end
endmodule
bind pasc_pin_alert_status_control pasc_pin_asserts u_chk (.*);
